// ==== hdl/dlrt_core.sv ====
/*
 * one prescaled up counter with auto reload and an overflow pulse.
 * assumes: controls come from the register logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module dlrt_core
    import dlrt_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // controls and state
    dlrt_core_if.core cif
);

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    logic [7:0] psc_cnt;
    logic [7:0] psc_lim;
    logic       step;
    logic       at_max;

    // divide by 1, 8, 64 or 256
    assign psc_lim = (cif.psc == 2'b00) ? PSC_LIM_1  :
                     (cif.psc == 2'b01) ? PSC_LIM_8  :
                     (cif.psc == 2'b10) ? PSC_LIM_64 : PSC_LIM_256;
    assign step    = cif.run && cif.tick && (psc_cnt >= psc_lim);
    assign at_max  = (cif.count == {W{1'b1}});

    // prescale count, restarted by a reload
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_cnt <= RST_BYTE;
        end else if (cif.ce) begin
            if (cif.reload || step) begin
                psc_cnt <= RST_BYTE;
            end else if (cif.run && cif.tick) begin
                psc_cnt <= psc_cnt + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // up count, reload on wrap or on request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cif.count <= '0;
            cif.ovf   <= 1'b0;
        end else if (cif.ce) begin
            cif.ovf <= step && at_max;
            if (cif.reload) begin
                cif.count <= cif.load;
            end else if (step) begin
                cif.count <= at_max ? cif.load : cif.count + 1'b1;
            end
        end
    end

endmodule : dlrt_core

`default_nettype wire

// ==== hdl/dlrt_core_if.sv ====
/*
 * carrier between the register logic and one counter core.
 * assumes: one instance per timer, same clock as the core.
 */
`timescale 1ns/1ns
`default_nettype none

interface dlrt_core_if #(parameter int W = 16);
    logic         ce;
    logic         run;
    logic         tick;
    logic [1:0]   psc;
    logic [W-1:0] load;
    logic         reload;
    logic [W-1:0] count;
    logic         ovf;

    modport core (input ce, run, tick, psc, load, reload, output count, ovf);
    modport ctrl (output ce, run, tick, psc, load, reload, input count, ovf);
endinterface : dlrt_core_if

`default_nettype wire

// ==== hdl/dlrt_pkg.sv ====
/*
 * constants for the dual reload timer pair: register indices, field
 * positions, reset values, mode codes, prescale limits, trigger states.
 * assumes: imported whole by every design module of the block.
 */
package dlrt_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_READBACK  = 8'h89;
    localparam logic [7:0] IDX_B_CTRL    = 8'hc0;
    localparam logic [7:0] IDX_A_CTRL    = 8'hc8;
    localparam logic [7:0] IDX_A_LOW     = 8'hcc;
    localparam logic [7:0] IDX_A_HIGH    = 8'hcd;
    localparam logic [7:0] IDX_B_LOW     = 8'hce;
    localparam logic [7:0] IDX_B_HIGH    = 8'hcf;
    localparam logic [7:0] IDX_IRQ_EN    = 8'hd0;
    localparam int         ADDR_IDX_LSB  = 2;
    localparam int         ADDR_IDX_MSB  = 9;
    localparam int         ADDR_TOP_LSB  = 10;

    // ----------------------------------------------------------------
    // control field positions
    // ----------------------------------------------------------------
    localparam int CTL_FLAG    = 7;
    localparam int CTL_TC      = 6;
    localparam int CTL_PS_HI   = 5;
    localparam int CTL_PS_LO   = 4;
    localparam int CTL_MODE_HI = 3;
    localparam int CTL_MODE_LO = 2;
    localparam int CTL_RUN     = 1;
    localparam int CTL_CLKS    = 0;
    localparam int RB_B_SEL    = 1;
    localparam int RB_OTHER    = 0;
    localparam int IEN_A       = 0;
    localparam int IEN_B       = 1;

    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [7:0]  B_CTL_MSK = 8'hb2;

    // ----------------------------------------------------------------
    // modes, prescale limits, baud divide
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_RELOAD = 2'b00;
    localparam logic [1:0] MODE_BAUD   = 2'b01;
    localparam logic [1:0] MODE_RISE   = 2'b10;
    localparam logic [1:0] MODE_FALL   = 2'b11;

    localparam logic [7:0] PSC_LIM_1   = 8'h00;
    localparam logic [7:0] PSC_LIM_8   = 8'h07;
    localparam logic [7:0] PSC_LIM_64  = 8'h3f;
    localparam logic [7:0] PSC_LIM_256 = 8'hff;

    localparam logic [4:0] BAUD_LIM_SYS = 5'h1f;
    localparam logic [4:0] BAUD_LIM_PIN = 5'h0f;

    typedef enum logic [1:0] {
        TRIG_IDLE  = 2'b00,
        TRIG_ARMED = 2'b01,
        TRIG_COUNT = 2'b11
    } dlrt_trig_t;

endpackage : dlrt_pkg

// ==== hdl/dlrt_top.sv ====
/*
 * dual reload timer pair: ahb-lite register slave, timer a with reload,
 * baud and triggered modes, timer b with reload only.
 * assumes: single ahb-lite master, word transfers; pin input asynchronous.
 */
`timescale 1ns/1ns
`default_nettype none

module dlrt_top
    import dlrt_pkg::*;
#(
    parameter int W = 16
) (
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // timer a pin
    input  wire logic        timer_a_pin_in,
    output logic             timer_a_pin_out,
    output logic             timer_a_pin_oe,
    output logic             timer_a_pullup_en,
    // interrupt controller and serial port
    input  wire logic        timer_a_vector_ack,
    input  wire logic        timer_b_vector_ack,
    output logic             timer_a_overflow_flag,
    output logic             timer_b_overflow_flag,
    output logic             timer_a_irq,
    output logic             timer_b_irq,
    output logic             baud_tick
);

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic [7:0]  timer_a_control;
    logic [7:0]  timer_b_control;
    logic [7:0]  readback_select;
    logic [1:0]  irq_enable;
    logic [W-1:0] load_a;
    logic [W-1:0] load_b;
    logic        dp_wr;
    logic        dp_rd;
    logic [7:0]  dp_idx;
    logic        dp_top_ok;
    logic [2:0]  pin_sync;
    logic        pin_lvl;
    logic        pin_rise;
    logic        pin_fall;
    logic [4:0]  baud_cnt;
    dlrt_trig_t  trig_st;
    dlrt_trig_t  next_trig_st;

    dlrt_core_if #(.W(W)) ifa ();
    dlrt_core_if #(.W(W)) ifb ();

    // ----------------------------------------------------------------
    // ahb-lite decode
    // ----------------------------------------------------------------
    logic        take;
    logic        wr_ok;
    logic        wr_ctl_a;
    logic        wr_ctl_b;
    logic        wr_rb;
    logic        wr_ien;
    logic        wr_lo_a;
    logic        wr_hi_a;
    logic        wr_lo_b;
    logic        wr_hi_b;
    logic [7:0]  wbyte;
    logic [W-1:0] view_b;
    logic [7:0]  rd_byte;

    // address phase accepted, data phase strobes
    assign take     = hsel && hready && htrans[1] && ce;
    assign wr_ok    = dp_wr && dp_top_ok && ce;
    assign wbyte    = hwdata[7:0];
    assign wr_ctl_a = wr_ok && (dp_idx == IDX_A_CTRL);
    assign wr_ctl_b = wr_ok && (dp_idx == IDX_B_CTRL);
    assign wr_rb    = wr_ok && (dp_idx == IDX_READBACK);
    assign wr_ien   = wr_ok && (dp_idx == IDX_IRQ_EN);
    assign wr_lo_a  = wr_ok && (dp_idx == IDX_A_LOW);
    assign wr_hi_a  = wr_ok && (dp_idx == IDX_A_HIGH);
    assign wr_lo_b  = wr_ok && (dp_idx == IDX_B_LOW);
    assign wr_hi_b  = wr_ok && (dp_idx == IDX_B_HIGH);

    // read mux; timer a pair shows the live count, timer b pair its load when readback selects it
    assign view_b  = readback_select[RB_B_SEL] ? load_b : ifb.count;
    assign rd_byte = !dp_top_ok                  ? RST_BYTE              :
                     (dp_idx == IDX_A_CTRL)      ? timer_a_control       :
                     (dp_idx == IDX_B_CTRL)      ? timer_b_control       :
                     (dp_idx == IDX_READBACK)    ? readback_select       :
                     (dp_idx == IDX_IRQ_EN)      ? {6'h00, irq_enable}   :
                     (dp_idx == IDX_A_LOW)       ? ifa.count[7:0]        :
                     (dp_idx == IDX_A_HIGH)      ? ifa.count[W-1:8]      :
                     (dp_idx == IDX_B_LOW)       ? view_b[7:0]           :
                     (dp_idx == IDX_B_HIGH)      ? view_b[W-1:8]         : RST_BYTE;

    // address capture; reads get one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr     <= 1'b0;
            dp_rd     <= 1'b0;
            dp_idx    <= RST_BYTE;
            dp_top_ok <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else if (ce) begin
            dp_wr <= take && hwrite;
            dp_rd <= take && !hwrite;
            if (take) begin
                dp_idx    <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
                dp_top_ok <= (haddr[31:ADDR_TOP_LSB] == 22'h00_0000);
            end
            hreadyout <= !(take && !hwrite);
            if (dp_rd) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // load registers and software control
    // ----------------------------------------------------------------
    // either byte of a pair writes the load register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_a          <= RST_WORD;
            load_b          <= RST_WORD;
            readback_select <= RST_BYTE;
            irq_enable      <= 2'b00;
        end else if (ce) begin
            if (wr_lo_a) load_a[7:0]   <= wbyte;
            if (wr_hi_a) load_a[W-1:8] <= wbyte;
            if (wr_lo_b) load_b[7:0]   <= wbyte;
            if (wr_hi_b) load_b[W-1:8] <= wbyte;
            if (wr_rb)   readback_select <= {6'h00, wbyte[RB_B_SEL:RB_OTHER]};
            if (wr_ien)  irq_enable <= wbyte[IEN_B:IEN_A];
        end
    end

    // ----------------------------------------------------------------
    // pin synchroniser and edge detect
    // ----------------------------------------------------------------
    // level accepted when second and third stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sync <= 3'b111;
            pin_lvl  <= 1'b1;
        end else if (ce) begin
            pin_sync <= {pin_sync[1:0], timer_a_pin_in};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_lvl <= pin_sync[2];
            end
        end
    end

    assign pin_rise = (pin_sync[1] == pin_sync[2]) && pin_sync[2] && !pin_lvl;
    assign pin_fall = (pin_sync[1] == pin_sync[2]) && !pin_sync[2] && pin_lvl;

    // ----------------------------------------------------------------
    // timer a mode decode
    // ----------------------------------------------------------------
    logic [1:0] mode_a;
    logic       run_a;
    logic       trig_mode;
    logic       trig_edge;
    logic       use_pin_clk;
    logic       compare_on;
    logic       retrig;

    assign mode_a      = timer_a_control[CTL_MODE_HI:CTL_MODE_LO];
    assign run_a       = timer_a_control[CTL_RUN];
    assign trig_mode   = mode_a[1];
    assign trig_edge   = (mode_a == MODE_RISE) ? pin_rise : pin_fall;
    assign use_pin_clk = timer_a_control[CTL_CLKS] && !trig_mode;
    assign compare_on  = (mode_a == MODE_RELOAD) && timer_a_control[CTL_TC];
    assign retrig      = trig_mode && (trig_st == TRIG_COUNT) && trig_edge
                         && timer_a_control[CTL_TC];

    // triggered mode: arm on run, count on edge, halt on overflow
    always_comb begin
        next_trig_st = trig_st;
        case (trig_st)
            TRIG_IDLE:  begin
                if (run_a && trig_mode) next_trig_st = TRIG_ARMED;
            end
            TRIG_ARMED: begin
                if (trig_edge) next_trig_st = TRIG_COUNT;
            end
            TRIG_COUNT: begin
                if (ifa.ovf) next_trig_st = TRIG_ARMED;
            end
            default:    next_trig_st = TRIG_IDLE;
        endcase
        if (!run_a || !trig_mode) next_trig_st = TRIG_IDLE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_st <= TRIG_IDLE;
        end else if (ce) begin
            trig_st <= next_trig_st;
        end
    end

    // ----------------------------------------------------------------
    // counter cores
    // ----------------------------------------------------------------
    // run never clears the count; high write reloads at once;
    // a triggered run drops in the overflow cycle so the reload holds
    assign ifa.ce     = ce;
    assign ifa.run    = trig_mode ? (trig_st == TRIG_COUNT && !ifa.ovf) : run_a;
    assign ifa.tick   = use_pin_clk ? pin_fall : 1'b1;
    assign ifa.psc    = timer_a_control[CTL_PS_HI:CTL_PS_LO];
    assign ifa.load   = wr_hi_a ? {wbyte, load_a[7:0]} : load_a;
    assign ifa.reload = wr_hi_a || retrig;

    assign ifb.ce     = ce;
    assign ifb.run    = timer_b_control[CTL_RUN];
    assign ifb.tick   = 1'b1;
    assign ifb.psc    = timer_b_control[CTL_PS_HI:CTL_PS_LO];
    assign ifb.load   = wr_hi_b ? {wbyte, load_b[7:0]} : load_b;
    assign ifb.reload = wr_hi_b;

    dlrt_core #(.W(W)) u_core_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cif     (ifa)
    );

    dlrt_core #(.W(W)) u_core_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cif     (ifb)
    );

    // ----------------------------------------------------------------
    // control registers, flags, pin and baud outputs
    // ----------------------------------------------------------------
    logic next_flag_a;
    logic next_flag_b;

    // overflow set wins over software write and vector clear
    assign next_flag_a = ifa.ovf || (!timer_a_vector_ack &&
                         (wr_ctl_a ? wbyte[CTL_FLAG] : timer_a_control[CTL_FLAG]));
    assign next_flag_b = ifb.ovf || (!timer_b_vector_ack &&
                         (wr_ctl_b ? wbyte[CTL_FLAG] : timer_b_control[CTL_FLAG]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_a_control <= RST_BYTE;
            timer_b_control <= RST_BYTE;
        end else if (ce) begin
            if (wr_ctl_a) timer_a_control[CTL_TC:0] <= wbyte[CTL_TC:0];
            if (wr_ctl_b) timer_b_control[CTL_TC:0] <= wbyte[CTL_TC:0] & B_CTL_MSK[CTL_TC:0];
            timer_a_control[CTL_FLAG] <= next_flag_a;
            timer_b_control[CTL_FLAG] <= next_flag_b;
        end
    end

    // irq outputs, compare pin, pull-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_a_irq           <= 1'b0;
            timer_b_irq           <= 1'b0;
            timer_a_overflow_flag <= 1'b0;
            timer_b_overflow_flag <= 1'b0;
            timer_a_pin_out       <= 1'b0;
            timer_a_pin_oe        <= 1'b0;
            timer_a_pullup_en     <= 1'b0;
        end else if (ce) begin
            timer_a_irq <= next_flag_a && irq_enable[IEN_A] && (mode_a != MODE_BAUD);
            timer_b_irq <= next_flag_b && irq_enable[IEN_B];
            timer_a_overflow_flag <= next_flag_a;
            timer_b_overflow_flag <= next_flag_b;
            timer_a_pin_oe        <= compare_on;
            timer_a_pullup_en     <= use_pin_clk && !compare_on;
            if (compare_on && ifa.ovf) begin
                timer_a_pin_out <= !timer_a_pin_out;
            end
        end
    end

    // baud tick every 16 (pin) or 32 (system) overflows
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_cnt  <= 5'h00;
            baud_tick <= 1'b0;
        end else if (ce) begin
            baud_tick <= 1'b0;
            if (mode_a != MODE_BAUD) begin
                baud_cnt <= 5'h00;
            end else if (ifa.ovf) begin
                if (baud_cnt >= (use_pin_clk ? BAUD_LIM_PIN : BAUD_LIM_SYS)) begin
                    baud_cnt  <= 5'h00;
                    baud_tick <= 1'b1;
                end else begin
                    baud_cnt <= baud_cnt + 5'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);

    a_wrap_reload: assert property (ifa.ovf |-> ifa.count == $past(ifa.load))
        else $error("timer a did not reload on wrap");
    a_flag_set: assert property (ifb.ovf |=> timer_b_overflow_flag)
        else $error("timer b flag not set after overflow");
    a_high_copy: assert property (wr_hi_a |=> ifa.count == $past(ifa.load))
        else $error("high byte write did not copy load");
    a_trig_arm: assert property ($rose(run_a) && trig_mode |=> trig_st == TRIG_ARMED ##1
        (trig_st == TRIG_ARMED || trig_edge || $past(trig_edge) || !run_a))
        else $error("triggered mode did not arm");
    a_trig_halt: assert property (trig_mode && run_a && ifa.ovf |=> !ifa.run)
        else $error("triggered timer kept counting after overflow");
    a_baud_no_irq: assert property (mode_a == MODE_BAUD && $past(mode_a) == MODE_BAUD
        |-> !timer_a_irq)
        else $error("baud mode raised an interrupt");
    a_cmp_toggle: assert property (compare_on && ifa.ovf |=>
        timer_a_pin_out != $past(timer_a_pin_out) && timer_a_pin_oe)
        else $error("compare pin did not toggle");
    a_ack_clear: assert property (timer_a_vector_ack && !ifa.ovf && !wr_ctl_a |=>
        !timer_a_overflow_flag)
        else $error("vector acknowledge left flag set");
    a_irq_b_gate: assert property (next_flag_b && irq_enable[IEN_B] |=> timer_b_irq)
        else $error("timer b interrupt missing");
    a_trig_clk: assert property (trig_mode |-> ifa.tick)
        else $error("triggered mode used pin clock");

    c_compare: cover property (compare_on && ifa.ovf);
    c_retrig: cover property (retrig);
    c_baud: cover property (baud_tick);
    c_read_b: cover property (dp_rd && dp_idx == IDX_B_HIGH && readback_select[RB_B_SEL]);

endmodule : dlrt_top

`default_nettype wire

// ==== sim/dlrt_pin_src.sv ====
/*
 * far side of the timer a pin: a push-pull pulse source.
 * assumes: the bench sets the source level, idle high like the pulled-up
 * pin; the timer drive wins.
 */
`timescale 1ns/1ns
`default_nettype none

module dlrt_pin_src (
    // source and timer drive
    input  wire logic src_lvl,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    // level seen by the timer
    output logic      pin_in
);
    // resolved wire level
    assign pin_in = pin_oe ? pin_out : src_lvl;
endmodule : dlrt_pin_src

`default_nettype wire

// ==== sim/dlrt_top_tb.sv ====
/*
 * bench for the timer pair: registers, overflow, compare, baud, trigger.
 * assumes: design package, top module and the pin source model.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end

module dlrt_top_tb import dlrt_pkg::*;;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic        ack_a = 1'b0, ack_b = 1'b0, src = 1'b1, p0;
    logic        rdy, hresp, pin_in, pin_out, pin_oe, pull, fa, fb, ia, ib, bt;
    logic [7:0]  rv;
    int          fails = 0, checked = 0, cyc = 0, n = 0;

    always #5 hclk = ~hclk;

    dlrt_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
        .hresp(hresp), .timer_a_pin_in(pin_in), .timer_a_pin_out(pin_out),
        .timer_a_pin_oe(pin_oe), .timer_a_pullup_en(pull),
        .timer_a_vector_ack(ack_a), .timer_b_vector_ack(ack_b),
        .timer_a_overflow_flag(fa), .timer_b_overflow_flag(fb),
        .timer_a_irq(ia), .timer_b_irq(ib), .baud_tick(bt));
    dlrt_pin_src src_u (.src_lvl(src), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in));

    // one single ahb-lite transfer, read byte lands in rv
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h00_0000, i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (rdy !== 1'b1);
        rv = hrdata[7:0];
    endtask : xfer

    // edges up to the next baud tick, counted in n
    task automatic wait_tick;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (bt !== 1'b1);
    endtask : wait_tick

    // counts, verdict, end of run
    task automatic close_out;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, IDX_A_CTRL, 8'h00); `CHK("a_ctrl rst", 8'h00, rv)
        `CHK("hresp", 1'b0, hresp)
        xfer(1'b0, 8'h10, 8'h00); `CHK("unmapped", 8'h00, rv)
        // low byte alone reaches load only; readback picks load or count
        xfer(1'b1, IDX_B_LOW, 8'h34);
        xfer(1'b1, IDX_READBACK, 8'h02);
        xfer(1'b0, IDX_B_LOW, 8'h00); `CHK("b load lo", 8'h34, rv)
        xfer(1'b1, IDX_READBACK, 8'h00);
        xfer(1'b0, IDX_B_LOW, 8'h00); `CHK("b count lo", 8'h00, rv)
        xfer(1'b1, IDX_B_HIGH, 8'h12);
        xfer(1'b0, IDX_B_HIGH, 8'h00); `CHK("b count hi", 8'h12, rv)
        xfer(1'b0, IDX_B_LOW, 8'h00); `CHK("b count lo2", 8'h34, rv)
        // timer b wraps, flags, interrupts, ack clears
        xfer(1'b1, IDX_B_LOW, 8'hf0);
        xfer(1'b1, IDX_B_HIGH, 8'hff);
        xfer(1'b1, IDX_IRQ_EN, 8'h02);
        xfer(1'b1, IDX_B_CTRL, 8'h02);
        repeat (24) @(posedge hclk);
        `CHK("b flag", 1'b1, fb)
        `CHK("b irq", 1'b1, ib)
        xfer(1'b1, IDX_B_CTRL, 8'h80);
        ack_b <= 1'b1;
        @(posedge hclk) ack_b <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK("b flag ack", 1'b0, fb)
        // timer b divided by 8: 69 running edges give 8 counts
        xfer(1'b1, IDX_B_LOW, 8'h00);
        xfer(1'b1, IDX_B_HIGH, 8'h00);
        xfer(1'b1, IDX_B_CTRL, 8'h12);
        repeat (66) @(posedge hclk);
        xfer(1'b1, IDX_B_CTRL, 8'h00);
        xfer(1'b0, IDX_B_HIGH, 8'h00); `CHK("psc hi", 8'h00, rv)
        xfer(1'b0, IDX_B_LOW, 8'h00); `CHK("psc lo", 8'h08, rv)
        // timer a compare toggles its pin per overflow, system clock kept
        xfer(1'b1, IDX_A_LOW, 8'hf0);
        xfer(1'b1, IDX_A_HIGH, 8'hff);
        xfer(1'b1, IDX_A_CTRL, 8'h42);
        repeat (4) @(posedge hclk);
        p0 = pin_out;
        `CHK("a oe", 1'b1, pin_oe)
        repeat (20) @(posedge hclk);
        `CHK("a pin", ~p0, pin_out)
        `CHK("a flag", 1'b1, fa)
        // baud mode: flag yes, interrupt no, tick every 32 overflows
        xfer(1'b1, IDX_A_CTRL, 8'h00);
        xfer(1'b1, IDX_A_LOW, 8'hfe);
        xfer(1'b1, IDX_A_HIGH, 8'hff);
        xfer(1'b1, IDX_IRQ_EN, 8'h01);
        xfer(1'b1, IDX_A_CTRL, 8'h06);
        wait_tick();
        wait_tick(); `CHK("baud period", 64, n)
        `CHK("baud irq", 1'b0, ia)
        `CHK("baud flag", 1'b1, fa)
        // triggered mode: armed ignores a fall, a rise runs once and halts
        xfer(1'b1, IDX_A_CTRL, 8'h00);
        xfer(1'b1, IDX_A_LOW, 8'hf0);
        xfer(1'b1, IDX_A_HIGH, 8'hff);
        xfer(1'b1, IDX_A_CTRL, 8'h0a);
        src <= 1'b0;
        repeat (30) @(posedge hclk);
        xfer(1'b0, IDX_A_LOW, 8'h00); `CHK("armed lo", 8'hf0, rv)
        `CHK("armed flag", 1'b0, fa)
        src <= 1'b1;
        repeat (40) @(posedge hclk);
        `CHK("trig irq", 1'b1, ia)
        xfer(1'b0, IDX_A_HIGH, 8'h00); `CHK("halt hi", 8'hff, rv)
        xfer(1'b0, IDX_A_LOW, 8'h00); `CHK("halt lo", 8'hf0, rv)
        ack_a <= 1'b1;
        @(posedge hclk) ack_a <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK("a flag ack", 1'b0, fa)
        `CHK("a irq ack", 1'b0, ia)
        // pin clock selects the pull-up and counts falling edges
        xfer(1'b1, IDX_A_CTRL, 8'h01);
        repeat (2) @(posedge hclk);
        `CHK("pullup", 1'b1, pull)
        xfer(1'b1, IDX_A_CTRL, 8'h03);
        repeat (3) begin
            src <= 1'b0;
            repeat (4) @(posedge hclk);
            src <= 1'b1;
            repeat (4) @(posedge hclk);
        end
        xfer(1'b0, IDX_A_HIGH, 8'h00); `CHK("pin hi", 8'hff, rv)
        xfer(1'b0, IDX_A_LOW, 8'h00); `CHK("pin lo", 8'hf3, rv)
        close_out();
    end
endmodule : dlrt_top_tb

`default_nettype wire
